// [mrs_defines.vh]
// constants for the serial port setup and supervision block
`ifndef MRS_DEFINES_VH
`define MRS_DEFINES_VH
`define MRS_CLK_HZ 125000000
`define MRS_MS_TIME 1
`define MRS_MS_CYCLES 17'h1E848
`define MRS_ADDR_ACTIVE 8'h00
`define MRS_ADDR_SETUP 8'h04
`define MRS_ADDR_DELAY 8'h08
`define MRS_ADDR_LOSS 8'h0C
`define MRS_ADDR_CMD 8'h10
`define MRS_ADDR_TXDATA 8'h14
`define MRS_ADDR_RXDATA 8'h18
`define MRS_ADDR_STATUS 8'h1C
`define MRS_ADDR_MASK 8'h20
`define MRS_ADDR_INPUTS 8'h24
`define MRS_ADDR_DRIVE 8'h28
`define MRS_ADDR_SRCSEL 8'h2C
`define MRS_ADDR_VMON 8'h30
`define MRS_ADDR_STATE 8'h34
`define MRS_NODE_RST 8'h1F
`define MRS_BAUD_RST 4'h3
`define MRS_PAR_RST 2'h0
`define MRS_SETUP_RST 6'h0F
`define MRS_DELAY_RST 7'h05
`define MRS_DELAY_MIN 7'h05
`define MRS_DELAY_MAX 7'h41
`define MRS_LOSS_RST 7'h14
`define MRS_LOSS_MAX 7'h64
`define MRS_LOSS_UNIT_MS 14'h0064
`define MRS_SRC_SERIAL 2'h2
`define MRS_GAP_BITS 6'h2C
`define MRS_STOP_POS 0
`define MRS_LOSSEN_POS 2
`define MRS_RTS_POS 3
`define MRS_UNIT_POS 4
`define MRS_COMMIT_POS 5
`define MRS_ST_RX 0
`define MRS_ST_RXERR 1
`define MRS_ST_CE 2
`define MRS_ST_TXDONE 3
`define MRS_BAUD0 1200
`define MRS_BAUD1 2400
`define MRS_BAUD2 4800
`define MRS_BAUD3 9600
`define MRS_BAUD4 19200
`define MRS_BAUD5 38400
`define MRS_BAUD6 57600
`define MRS_BAUD7 76800
`define MRS_BAUD8 115200
`endif

// [mrs_serial_setup.v]
// serial slave port setup, framing, response timing and loss watchdog
// Function
// - node address default 1FH; zero means silent
// - address, rate, parity apply after reset only
// - rate codes 0..8 give 1200..115200, default 3
// - parity: 0 none, 1 even, 2 odd
// - loss fault picks ramp, emergency, coast, alarm
// - enabled watchdog raises fault on silence
// - detection time 0.0..10.0 s, default 2.0
// - response waits 5..65 ms, default 5
// - transmit enable always on or only sending
// - voltage monitor in 0.1 V or 1 V
// - commit selector 0: delay, loss, other setup bits wait for commit
// - commit selector 1: writes apply immediately
// - monitoring and setting access never gated
// - input equals terminal OR serial value
// - serial control only when both sources 2
// - broadcast requests executed, never answered
`timescale 1ns/1ns
`default_nettype none
`include "mrs_defines.vh"
module mrs_serial_setup #(
   parameter [16:0] MS_CYCLES = `MRS_MS_CYCLES
) (
   // clock and reset
   input wire clk_sys_in,
   input wire arst_n_in,
   // register port
   input wire [7:0] addr_in,
   input wire [31:0] wr_data_in,
   input wire wr_in,
   input wire rd_in,
   output reg [31:0] rd_data_out,
   // stored settings, caught after reset
   input wire [7:0] stored_node_in,
   input wire [3:0] stored_rate_in,
   input wire [1:0] stored_parity_in,
   // serial line
   input wire rx_in,
   output reg tx_out,
   output reg tx_en_out,
   // drive side
   input wire [7:0] terminal_in,
   input wire [15:0] vout_in,
   output reg [7:0] mfi_out,
   output reg serial_ctrl_out,
   output reg run_fwd_out,
   output reg run_rev_out,
   output reg [15:0] speed_ref_out,
   output reg ce_fault_out,
   output reg [1:0] ce_stop_out,
   output reg irq_out
);
   localparam [1:0] RX_IDLE = 2'h0;
   localparam [1:0] RX_START = 2'h1;
   localparam [1:0] RX_BITS = 2'h2;
   localparam [1:0] RX_STOP = 2'h3;

   function [16:0] baud_div;
      input [3:0] code;
      reg [31:0] q;
      begin
         case (code)
            4'h0: q = `MRS_CLK_HZ / `MRS_BAUD0;
            4'h1: q = `MRS_CLK_HZ / `MRS_BAUD1;
            4'h2: q = `MRS_CLK_HZ / `MRS_BAUD2;
            4'h3: q = `MRS_CLK_HZ / `MRS_BAUD3;
            4'h4: q = `MRS_CLK_HZ / `MRS_BAUD4;
            4'h5: q = `MRS_CLK_HZ / `MRS_BAUD5;
            4'h6: q = `MRS_CLK_HZ / `MRS_BAUD6;
            4'h7: q = `MRS_CLK_HZ / `MRS_BAUD7;
            default: q = `MRS_CLK_HZ / `MRS_BAUD8;
         endcase
         // every divisor fits in 17 bits
         baud_div = q[16:0];
      end
   endfunction

   function [6:0] clamp7;
      input [6:0] v;
      input [6:0] lo;
      input [6:0] hi;
      begin
         clamp7 = (v < lo) ? lo : ((v > hi) ? hi : v);
      end
   endfunction

   // synchronisers
   reg [1:0] rx_sync_ff;
   reg [7:0] term_s1_ff, term_s2_ff;
   always @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         rx_sync_ff <= 2'h3;
         term_s1_ff <= 8'h00;
         term_s2_ff <= 8'h00;
      end else begin
         rx_sync_ff <= {rx_sync_ff[0], rx_in};
         term_s1_ff <= terminal_in;
         term_s2_ff <= term_s1_ff;
      end
   end
   wire rxs = rx_sync_ff[1];

   // register state
   reg cap_done_ff;
   reg [7:0] node_ff;
   reg [3:0] rate_ff;
   reg [1:0] par_ff;
   reg [5:0] stg_setup_ff, act_setup_ff;
   reg [6:0] stg_delay_ff, act_delay_ff, stg_loss_ff, act_loss_ff;
   reg [3:0] status_ff, mask_ff;
   reg [7:0] ser_in_ff;
   reg [17:0] drive_ff;
   reg [3:0] srcsel_ff;
   reg [7:0] rx_data_ff;
   reg rx_first_ff;
   wire wr_cmd = wr_in && (addr_in == `MRS_ADDR_CMD);
   wire wr_tx = wr_in && (addr_in == `MRS_ADDR_TXDATA);
   wire commit_now = act_setup_ff[`MRS_COMMIT_POS];
   wire do_commit = wr_cmd && wr_data_in[0];
   wire req_ok = wr_cmd && wr_data_in[1];
   wire fault_rst = wr_cmd && wr_data_in[2];
   wire [1:0] stop_m = act_setup_ff[`MRS_STOP_POS +: 2];
   wire loss_en = act_setup_ff[`MRS_LOSSEN_POS];
   wire rts_on = act_setup_ff[`MRS_RTS_POS];
   wire volt_unit = act_setup_ff[`MRS_UNIT_POS];
   wire [16:0] div = baud_div(rate_ff);
   wire [16:0] half = {1'b0, div[16:1]};
   wire par_use = (par_ff == 2'h1) || (par_ff == 2'h2);

   // event wires from the serial engines
   reg rx_done, rx_err, ce_set, tx_done;

   always @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         cap_done_ff <= 1'b0;
         node_ff <= `MRS_NODE_RST;
         rate_ff <= `MRS_BAUD_RST;
         par_ff <= `MRS_PAR_RST;
         stg_setup_ff <= `MRS_SETUP_RST;
         act_setup_ff <= `MRS_SETUP_RST;
         stg_delay_ff <= `MRS_DELAY_RST;
         act_delay_ff <= `MRS_DELAY_RST;
         stg_loss_ff <= `MRS_LOSS_RST;
         act_loss_ff <= `MRS_LOSS_RST;
         status_ff <= 4'h0;
         mask_ff <= 4'h0;
         ser_in_ff <= 8'h00;
         drive_ff <= 18'h00000;
         srcsel_ff <= 4'h0;
      end else begin
         // stored port settings only ever load once per reset
         cap_done_ff <= 1'b1;
         if (!cap_done_ff) begin
            node_ff <= stored_node_in;
            rate_ff <= (stored_rate_in > 4'h8) ? `MRS_BAUD_RST : stored_rate_in;
            par_ff <= (stored_parity_in == 2'h3) ? `MRS_PAR_RST : stored_parity_in;
         end
         // only a transmit data write is ever refused, outside the response window or while busy
         if (wr_in && addr_in == `MRS_ADDR_SETUP)
            stg_setup_ff <= wr_data_in[5:0];
         if (wr_in && addr_in == `MRS_ADDR_DELAY)
            stg_delay_ff <= clamp7(wr_data_in[6:0], `MRS_DELAY_MIN, `MRS_DELAY_MAX);
         if (wr_in && addr_in == `MRS_ADDR_LOSS)
            stg_loss_ff <= clamp7(wr_data_in[6:0], 7'h00, `MRS_LOSS_MAX);
         if (commit_now) begin
            // staged values follow straight through
            if (wr_in && addr_in == `MRS_ADDR_SETUP)
               act_setup_ff <= wr_data_in[5:0];
            if (wr_in && addr_in == `MRS_ADDR_DELAY)
               act_delay_ff <= clamp7(wr_data_in[6:0], `MRS_DELAY_MIN, `MRS_DELAY_MAX);
            if (wr_in && addr_in == `MRS_ADDR_LOSS)
               act_loss_ff <= clamp7(wr_data_in[6:0], 7'h00, `MRS_LOSS_MAX);
         end else if (do_commit) begin
            act_setup_ff <= stg_setup_ff;
            act_delay_ff <= stg_delay_ff;
            act_loss_ff <= stg_loss_ff;
         end else if (wr_in && addr_in == `MRS_ADDR_SETUP) begin
            // the commit selector itself never waits
            act_setup_ff[`MRS_COMMIT_POS] <= wr_data_in[`MRS_COMMIT_POS];
         end
         if (wr_in && addr_in == `MRS_ADDR_MASK)
            mask_ff <= wr_data_in[3:0];
         if (wr_in && addr_in == `MRS_ADDR_INPUTS)
            ser_in_ff <= wr_data_in[7:0];
         if (wr_in && addr_in == `MRS_ADDR_DRIVE)
            drive_ff <= {wr_data_in[31:16], wr_data_in[1:0]};
         if (wr_in && addr_in == `MRS_ADDR_SRCSEL)
            srcsel_ff <= wr_data_in[3:0];
         // write one clears, a new event in the same cycle wins
         status_ff <= (status_ff & ~((wr_in && addr_in == `MRS_ADDR_STATUS) ?
                      wr_data_in[3:0] : 4'h0)) | {tx_done, ce_set, rx_err, rx_done};
      end
   end

   // one millisecond tick
   reg [16:0] ms_cnt_ff;
   wire ms_tick = (ms_cnt_ff == MS_CYCLES - 17'h00001);
   always @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in)
         ms_cnt_ff <= 17'h00000;
      else
         ms_cnt_ff <= ms_tick ? 17'h00000 : ms_cnt_ff + 17'h00001;
   end

   // receiver and frame gap detector
   reg [1:0] rx_st_ff;
   reg [16:0] rx_cnt_ff, gap_pre_ff;
   reg [3:0] rx_idx_ff;
   reg [7:0] rx_sh_ff;
   reg rx_par_ff, new_frame_ff;
   reg [5:0] gap_bits_ff;
   reg [7:0] frame_addr_ff;
   wire [3:0] rx_last = par_use ? 4'h8 : 4'h7;
   wire par_bad = par_use && (rx_par_ff != ((par_ff == 2'h1) ? ^rx_sh_ff : ~^rx_sh_ff));
   always @* begin
      rx_done = 1'b0;
      rx_err = 1'b0;
      if (rx_st_ff == RX_STOP && rx_cnt_ff == 17'h00000) begin
         rx_done = rxs;
         rx_err = !rxs || par_bad;
      end
   end
   always @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         rx_st_ff <= RX_IDLE;
         rx_cnt_ff <= 17'h00000;
         rx_idx_ff <= 4'h0;
         rx_sh_ff <= 8'h00;
         rx_par_ff <= 1'b0;
         rx_data_ff <= 8'h00;
         rx_first_ff <= 1'b0;
         gap_pre_ff <= 17'h00000;
         gap_bits_ff <= 6'h00;
         new_frame_ff <= 1'b1;
         frame_addr_ff <= 8'h00;
      end else begin
         if (rx_st_ff != RX_IDLE || !rxs) begin
            gap_pre_ff <= 17'h00000;
            gap_bits_ff <= 6'h00;
         end else if (gap_bits_ff != `MRS_GAP_BITS) begin
            gap_pre_ff <= (gap_pre_ff == div) ? 17'h00000 : gap_pre_ff + 17'h00001;
            if (gap_pre_ff == div)
               gap_bits_ff <= gap_bits_ff + 6'h01;
         end else
            new_frame_ff <= 1'b1;
         rx_cnt_ff <= (rx_cnt_ff == 17'h00000) ? div : rx_cnt_ff - 17'h00001;
         case (rx_st_ff)
            RX_IDLE: if (!rxs) begin
               rx_st_ff <= RX_START;
               rx_cnt_ff <= half;
            end
            RX_START: if (rx_cnt_ff == 17'h00000) begin
               rx_st_ff <= rxs ? RX_IDLE : RX_BITS;
               rx_idx_ff <= 4'h0;
            end
            RX_BITS: if (rx_cnt_ff == 17'h00000) begin
               if (rx_idx_ff[3])
                  rx_par_ff <= rxs;
               else
                  rx_sh_ff <= {rxs, rx_sh_ff[7:1]};
               rx_idx_ff <= rx_idx_ff + 4'h1;
               if (rx_idx_ff == rx_last)
                  rx_st_ff <= RX_STOP;
            end
            RX_STOP: if (rx_cnt_ff == 17'h00000)
               rx_st_ff <= RX_IDLE;
            default: rx_st_ff <= RX_IDLE;
         endcase
         if (rx_done) begin
            rx_data_ff <= rx_sh_ff;
            rx_first_ff <= new_frame_ff;
            new_frame_ff <= 1'b0;
            if (new_frame_ff)
               frame_addr_ff <= rx_sh_ff;
         end
      end
   end

   // request acceptance, response delay and watchdog
   wire for_us = (frame_addr_ff == node_ff) || (frame_addr_ff == 8'h00);
   wire may_answer = (node_ff != 8'h00) && (frame_addr_ff == node_ff);
   reg [6:0] resp_cnt_ff;
   reg resp_pend_ff, resp_open_ff;
   reg [13:0] loss_ms_ff;
   reg ce_ff;
   wire [13:0] loss_lim = act_loss_ff * `MRS_LOSS_UNIT_MS;
   always @* begin
      ce_set = loss_en && !ce_ff && (loss_ms_ff > loss_lim);
   end
   always @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         resp_cnt_ff <= 7'h00;
         resp_pend_ff <= 1'b0;
         resp_open_ff <= 1'b0;
         loss_ms_ff <= 14'h0000;
         ce_ff <= 1'b0;
      end else begin
         if (req_ok && may_answer) begin
            // one extra tick so the wait is never short of the setting
            resp_cnt_ff <= act_delay_ff + 7'h01;
            resp_pend_ff <= 1'b1;
            resp_open_ff <= 1'b0;
         end else if (resp_pend_ff && ms_tick) begin
            resp_cnt_ff <= resp_cnt_ff - 7'h01;
            if (resp_cnt_ff == 7'h01) begin
               resp_pend_ff <= 1'b0;
               resp_open_ff <= 1'b1;
            end
         end else if (new_frame_ff && rx_done)
            resp_open_ff <= 1'b0;
         if (!loss_en || (req_ok && for_us))
            loss_ms_ff <= 14'h0000;
         else if (ms_tick && loss_ms_ff != 14'h3FFF)
            loss_ms_ff <= loss_ms_ff + 14'h0001;
         if (ce_set)
            ce_ff <= 1'b1;
         else if (fault_rst)
            ce_ff <= 1'b0;
      end
   end

   // transmitter
   reg tx_busy_ff;
   reg [10:0] tx_sh_ff;
   reg [3:0] tx_left_ff;
   reg [16:0] tx_cnt_ff;
   wire tx_par = (par_ff == 2'h1) ? ^wr_data_in[7:0] : ~^wr_data_in[7:0];
   wire tx_start = wr_tx && !tx_busy_ff && resp_open_ff;
   always @* begin
      tx_done = tx_busy_ff && tx_left_ff == 4'h1 && tx_cnt_ff == 17'h00000;
   end
   always @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         tx_busy_ff <= 1'b0;
         tx_sh_ff <= 11'h7FF;
         tx_left_ff <= 4'h0;
         tx_cnt_ff <= 17'h00000;
      end else if (tx_start) begin
         tx_busy_ff <= 1'b1;
         tx_sh_ff <= par_use ? {1'b1, tx_par, wr_data_in[7:0], 1'b0} :
                     {2'b11, wr_data_in[7:0], 1'b0};
         tx_left_ff <= par_use ? 4'hB : 4'hA;
         tx_cnt_ff <= div;
      end else if (tx_busy_ff) begin
         tx_cnt_ff <= (tx_cnt_ff == 17'h00000) ? div : tx_cnt_ff - 17'h00001;
         if (tx_cnt_ff == 17'h00000) begin
            tx_sh_ff <= {1'b1, tx_sh_ff[10:1]};
            tx_left_ff <= tx_left_ff - 4'h1;
            if (tx_done)
               tx_busy_ff <= 1'b0;
         end
      end
   end

   // read mux and registered outputs
   wire [15:0] vmon = volt_unit ? vout_in / 16'h000A : vout_in;
   reg [31:0] nxt_rd;
   always @* begin
      case (addr_in)
         `MRS_ADDR_ACTIVE: nxt_rd = {18'h00000, par_ff, rate_ff, node_ff};
         `MRS_ADDR_SETUP: nxt_rd = {20'h00000, act_setup_ff, stg_setup_ff};
         `MRS_ADDR_DELAY: nxt_rd = {9'h000, act_delay_ff, 9'h000, stg_delay_ff};
         `MRS_ADDR_LOSS: nxt_rd = {9'h000, act_loss_ff, 9'h000, stg_loss_ff};
         `MRS_ADDR_RXDATA: nxt_rd = {23'h000000, rx_first_ff, rx_data_ff};
         `MRS_ADDR_STATUS: nxt_rd = {28'h0000000, status_ff};
         `MRS_ADDR_MASK: nxt_rd = {28'h0000000, mask_ff};
         `MRS_ADDR_INPUTS: nxt_rd = {24'h000000, ser_in_ff};
         `MRS_ADDR_DRIVE: nxt_rd = {drive_ff[17:2], 14'h0000, drive_ff[1:0]};
         `MRS_ADDR_SRCSEL: nxt_rd = {28'h0000000, srcsel_ff};
         `MRS_ADDR_VMON: nxt_rd = {16'h0000, vmon};
         `MRS_ADDR_STATE: nxt_rd = {12'h000, frame_addr_ff, 7'h00, ce_ff,
                                    resp_pend_ff, resp_open_ff, tx_busy_ff, rx_st_ff != RX_IDLE};
         default: nxt_rd = 32'h00000000;
      endcase
   end
   wire nxt_serial = (srcsel_ff[1:0] == `MRS_SRC_SERIAL) &&
                     (srcsel_ff[3:2] == `MRS_SRC_SERIAL);
   always @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         rd_data_out <= 32'h00000000;
         tx_out <= 1'b1;
         tx_en_out <= 1'b0;
         mfi_out <= 8'h00;
         serial_ctrl_out <= 1'b0;
         run_fwd_out <= 1'b0;
         run_rev_out <= 1'b0;
         speed_ref_out <= 16'h0000;
         ce_fault_out <= 1'b0;
         ce_stop_out <= 2'h0;
         irq_out <= 1'b0;
      end else begin
         rd_data_out <= rd_in ? nxt_rd : 32'h00000000;
         tx_out <= tx_busy_ff ? tx_sh_ff[0] : 1'b1;
         tx_en_out <= rts_on ? tx_busy_ff : 1'b1;
         mfi_out <= term_s2_ff | ser_in_ff;
         serial_ctrl_out <= nxt_serial;
         run_fwd_out <= nxt_serial && drive_ff[0];
         run_rev_out <= nxt_serial && drive_ff[1];
         speed_ref_out <= nxt_serial ? drive_ff[17:2] : 16'h0000;
         ce_fault_out <= ce_ff;
         ce_stop_out <= stop_m;
         irq_out <= |(status_ff & mask_ff);
      end
   end
endmodule
`default_nettype wire

// [mrs_serial_setup_props.sv]
// assertions on the ports of the serial setup block
`timescale 1ns/1ns
`default_nettype none
`include "mrs_defines.vh"
module mrs_serial_setup_chk (
   // clock and reset
   input wire logic clk_sys_in,
   input wire logic arst_n_in,
   // register port
   input wire logic [7:0] addr_in,
   input wire logic [31:0] wr_data_in,
   input wire logic wr_in,
   input wire logic rd_in,
   input wire logic [31:0] rd_data_out,
   // serial and drive side
   input wire logic tx_out,
   input wire logic tx_en_out,
   input wire logic [7:0] terminal_in,
   input wire logic [7:0] mfi_out,
   input wire logic serial_ctrl_out,
   input wire logic run_fwd_out,
   input wire logic run_rev_out,
   input wire logic [15:0] speed_ref_out,
   input wire logic ce_fault_out
);
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!arst_n_in);
   wire logic clr_now = wr_in && addr_in == `MRS_ADDR_CMD && wr_data_in[2];
   wire logic src_wr = wr_in && addr_in == `MRS_ADDR_SRCSEL;
   logic clr_ff;
   // remembers a fault clear so the latch may drop one cycle later
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         clr_ff <= 1'b0;
      end else begin
         clr_ff <= clr_now;
      end
   end
   a_rd_idle_zero: assert property (!rd_in |=> rd_data_out == 32'h0)
      else $error("read data not zero outside read slot");
   a_tx_low_enabled: assert property (!tx_out |-> tx_en_out)
      else $error("line driven low while transmitter disabled");
   a_txen_drop_idle: assert property ($fell(tx_en_out) |-> tx_out)
      else $error("transmitter disabled in mid character");
   a_start_bit_held: assert property ($fell(tx_out) |-> !tx_out [*8])
      else $error("start bit too short");
   a_fault_holds: assert property (ce_fault_out && !clr_now && !clr_ff |=> ce_fault_out)
      else $error("loss fault dropped without clear");
   a_ctrl_gate: assert property (!serial_ctrl_out && !$past(serial_ctrl_out)
      |-> !run_fwd_out && !run_rev_out && speed_ref_out == 16'h0)
      else $error("serial run or speed passed without serial control");
   a_ctrl_set_both: assert property (src_wr && wr_data_in[3:0] == 4'hA
      |-> ##[1:3] serial_ctrl_out) else $error("serial control not taken");
   a_ctrl_clear_one: assert property (src_wr && wr_data_in[1:0] != 2'h2
      |-> ##[1:3] !serial_ctrl_out) else $error("serial control kept");
   a_mfi_term_or: assert property ($stable(terminal_in) [*5] ##0 $past(arst_n_in, 4)
      |-> (mfi_out & terminal_in) == terminal_in) else $error("terminal input lost");
   c_fault: cover property ($rose(ce_fault_out));
   c_tx_char: cover property ($fell(tx_out));
   c_ctrl_on: cover property ($rose(serial_ctrl_out));
endmodule
bind mrs_serial_setup mrs_serial_setup_chk mrs_serial_setup_chk_inst (
   .clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .addr_in(addr_in),
   .wr_data_in(wr_data_in), .wr_in(wr_in), .rd_in(rd_in), .rd_data_out(rd_data_out),
   .tx_out(tx_out), .tx_en_out(tx_en_out), .terminal_in(terminal_in), .mfi_out(mfi_out),
   .serial_ctrl_out(serial_ctrl_out), .run_fwd_out(run_fwd_out),
   .run_rev_out(run_rev_out), .speed_ref_out(speed_ref_out), .ce_fault_out(ce_fault_out));
`default_nettype wire

// [mrs_master_model.sv]
// serial master model: sends request characters, decodes replies
`timescale 1ns/1ns
`default_nettype none
module mrs_master_model #(
   parameter int BIT_CYC = 1086
) (
   // clock
   input wire logic clk_sys_in,
   // serial line
   output var logic line_out,
   input wire logic line_in
);
   initial line_out = 1'b1;
   // start, data lsb first, parity or idle filler, stop
   task automatic send_byte(input logic [7:0] d, input logic [1:0] par);
      logic [10:0] b;
      b = {1'b1, (par == 2'h0) ? 1'b1 : (par == 2'h2) ? ~^d : ^d, d, 1'b0};
      @(posedge clk_sys_in);
      for (int i = 0; i < 11; i++) begin
         line_out <= b[i];
         repeat (BIT_CYC) @(posedge clk_sys_in);
      end
   endtask
   task automatic get_byte(input logic [1:0] par, output logic [7:0] d, output logic ok);
      int t;
      t = 0;
      ok = 1'b0;
      d = 8'h00;
      while (line_in !== 1'b0 && t < 40000) begin
         @(posedge clk_sys_in);
         t++;
      end
      if (line_in === 1'b0) begin
         repeat (BIT_CYC / 2) @(posedge clk_sys_in);
         for (int i = 0; i < 8; i++) begin
            repeat (BIT_CYC) @(posedge clk_sys_in);
            d[i] = line_in;
         end
         ok = 1'b1;
         if (par != 2'h0) begin
            repeat (BIT_CYC) @(posedge clk_sys_in);
            ok = (line_in === ((par == 2'h2) ? ~^d : ^d));
         end
         repeat (BIT_CYC) @(posedge clk_sys_in);
         ok = ok && line_in === 1'b1;
      end
   endtask
endmodule
`default_nettype wire

// [tb_top.sv]
// self-checking testbench of the serial setup block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   localparam int MS = 50;
   localparam int BIT_CYC = 1086;
   logic clk_sys_in = 1'b0;
   logic arst_n_in = 1'b0;
   logic [7:0] addr_in = 8'h00;
   logic [31:0] wr_data_in = 32'h0;
   logic wr_in = 1'b0;
   logic rd_in = 1'b0;
   logic [7:0] stored_node_in = 8'h1F;
   logic [3:0] stored_rate_in = 4'hF;
   logic [1:0] stored_parity_in = 2'h3;
   logic [7:0] terminal_in = 8'h0A;
   logic [15:0] vout_in = 16'h04D2;
   wire logic rx_in;
   wire logic [31:0] rd_data_out;
   wire logic tx_out, tx_en_out, serial_ctrl_out, run_fwd_out, run_rev_out;
   wire logic ce_fault_out, irq_out;
   wire logic [7:0] mfi_out;
   wire logic [15:0] speed_ref_out;
   wire logic [1:0] ce_stop_out;
   int mismatches = 0;
   int n_compared = 0;
   int cycles = 0;
   always #4 clk_sys_in = ~clk_sys_in;
   mrs_serial_setup #(.MS_CYCLES(17'h00032)) mrs_serial_setup_inst (
      .clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .addr_in(addr_in),
      .wr_data_in(wr_data_in), .wr_in(wr_in), .rd_in(rd_in), .rd_data_out(rd_data_out),
      .stored_node_in(stored_node_in), .stored_rate_in(stored_rate_in),
      .stored_parity_in(stored_parity_in), .rx_in(rx_in), .tx_out(tx_out),
      .tx_en_out(tx_en_out), .terminal_in(terminal_in), .vout_in(vout_in),
      .mfi_out(mfi_out), .serial_ctrl_out(serial_ctrl_out), .run_fwd_out(run_fwd_out),
      .run_rev_out(run_rev_out), .speed_ref_out(speed_ref_out),
      .ce_fault_out(ce_fault_out), .ce_stop_out(ce_stop_out), .irq_out(irq_out));
   mrs_master_model #(.BIT_CYC(BIT_CYC)) mrs_master_model_inst (
      .clk_sys_in(clk_sys_in), .line_out(rx_in), .line_in(tx_out));
   task automatic print_verdict();
      $display("TB: compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   always @(posedge clk_sys_in) begin
      cycles++;
      if (cycles == 100000) begin
         mismatches++;
         print_verdict();
      end
   end
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys_in);
      addr_in <= a;
      wr_data_in <= d;
      wr_in <= 1'b1;
      @(posedge clk_sys_in);
      wr_in <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk_sys_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge clk_sys_in);
      rd_in <= 1'b0;
      @(negedge clk_sys_in);
      d = rd_data_out;
   endtask
   task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] d;
      rd(a, d);
      chk(name, exp, d);
   endtask
   // waits whole cycles, then lands between edges for sampling
   task automatic wt(input int n);
      repeat (n) @(posedge clk_sys_in);
      @(negedge clk_sys_in);
   endtask
   task automatic do_reset();
      @(posedge clk_sys_in);
      arst_n_in <= 1'b0;
      repeat (16) @(posedge clk_sys_in);
      arst_n_in <= 1'b1;
      repeat (2) @(posedge clk_sys_in);
   endtask
   task automatic test_power_up();
      rd_chk("active", 8'h00, 32'h031F);
      rd_chk("setup", 8'h04, 32'h03CF);
      chk("stop", 32'h3, {30'h0, ce_stop_out});
      chk("txen", 32'h0, {31'h0, tx_en_out});
      @(posedge clk_sys_in);
      stored_node_in <= 8'h05;
      stored_rate_in <= 4'h8;
      stored_parity_in <= 2'h1;
      rd_chk("active_held", 8'h00, 32'h031F);
      do_reset();
      rd_chk("active_new", 8'h00, 32'h1805);
   endtask
   task automatic test_loss_commit();
      int c;
      wr(8'h0C, 32'h1);
      wr(8'h04, 32'h0D);
      rd_chk("loss_staged", 8'h0C, 32'h00140001);
      chk("stop_staged", 32'h3, {30'h0, ce_stop_out});
      wr(8'h10, 32'h1);
      rd_chk("loss_commit", 8'h0C, 32'h00010001);
      chk("stop_commit", 32'h1, {30'h0, ce_stop_out});
      wr(8'h20, 32'h4);
      c = 0;
      while (ce_fault_out !== 1'b1 && c < 6000) begin
         @(negedge clk_sys_in);
         c++;
      end
      chk("loss_time", 32'h1, {31'h0, c >= 4850 && c <= 5150});
      wt(2);
      chk("irq_set", 32'h1, {31'h0, irq_out});
      rd_chk("status", 8'h1C, 32'h4);
      wr(8'h04, 32'h2D);
      for (int k = 0; k < 4; k++) begin
         wr(8'h04, 32'h28 | k);
         rd_chk("setup_now", 8'h04, ((32'h28 | k) << 6) | 32'h28 | k);
         chk("stop_now", k, {30'h0, ce_stop_out});
      end
      wr(8'h10, 32'h4);
      wr(8'h1C, 32'h4);
      wt(3);
      chk("fault_clr", 32'h0, {30'h0, ce_fault_out, irq_out});
   endtask
   task automatic test_drive_side();
      wr(8'h24, 32'h50);
      wt(3);
      chk("mfi", 32'h5A, {24'h0, mfi_out});
      wr(8'h28, 32'h12340003);
      wr(8'h2C, 32'h6);
      wt(3);
      chk("ctrl_off", 32'h0, {13'h0, serial_ctrl_out, run_rev_out, run_fwd_out,
         speed_ref_out});
      wr(8'h2C, 32'hA);
      wt(3);
      chk("ctrl_on", 32'h71234, {13'h0, serial_ctrl_out, run_rev_out, run_fwd_out,
         speed_ref_out});
      rd_chk("vmon_tenth", 8'h30, 32'd1234);
      wr(8'h04, 32'h3B);
      rd_chk("vmon_volt", 8'h30, 32'd123);
      wr(8'h04, 32'h2B);
   endtask
   task automatic test_serial();
      logic [31:0] s;
      logic [7:0] d;
      logic ok;
      mrs_master_model_inst.send_byte(8'h00, 2'h1);
      rd_chk("rx_bcast", 8'h18, 32'h100);
      wr(8'h10, 32'h2);
      wt(7 * MS);
      rd(8'h34, s);
      chk("open_bcast", 32'h0, {31'h0, s[2]});
      wt(45 * BIT_CYC);
      mrs_master_model_inst.send_byte(8'h05, 2'h1);
      rd_chk("rx_node", 8'h18, 32'h105);
      wr(8'h10, 32'h2);
      wt(5 * MS - 10);
      rd(8'h34, s);
      chk("open_early", 32'h0, {31'h0, s[2]});
      wt(2 * MS + 10);
      rd(8'h34, s);
      chk("open_late", 32'h1, {31'h0, s[2]});
      fork
         mrs_master_model_inst.get_byte(2'h1, d, ok);
         wr(8'h14, 32'hA5);
      join
      chk("tx_byte", 32'hA5, {24'h0, d});
      chk("tx_frame", 32'h1, {31'h0, ok});
      wt(BIT_CYC);
      chk("txen_idle", 32'h0, {31'h0, tx_en_out});
      rd_chk("status_io", 8'h1C, 32'h9);
      wr(8'h04, 32'h23);
      wt(2);
      chk("txen_on", 32'h1, {31'h0, tx_en_out});
      chk("no_fault", 32'h0, {31'h0, ce_fault_out});
   endtask
   initial begin
      do_reset();
      test_power_up();
      test_loss_commit();
      test_drive_side();
      test_serial();
      print_verdict();
   end
endmodule
`default_nettype wire
